// [gpio_line_message_irq_engine.sv]
`timescale 1ns/10ps
// Summary of operation
// - Set-level stores level, drives it when output, replies value zero.
// - Delivery needs both enable by trigger request and unmask by posting.
// - Edge triggers latch from enable onward, even masked; report on unmask.
// - Level triggers never latch; report only while enabled and unmasked.
// - Disabling with no-trigger clears any latched event of the line.
// - All lines masked after reset; one posted pair unmasks one line.
// - Active interrupt returns pair with valid status, line masks again.
// - Disable or unmask without enable returns pair invalid, masked.
// - Every command response fully filled with ok or error status.
// - Request fields only read by device; only response written.
// - Same-line messages execute and answer in arrival order.
// - Different-line messages may complete in any order.
// - Direction none discards level, trigger and latched events.
// - Names block size reads zero since no line names exist.
// - Event post carries 16-bit line number, must be below count.
// - Set-level type 0x0005, set-trigger type 0x0006.
// - Trigger codes 0,1,2,3,4 and 0x08 for none to level low.
// - Direction 0 none deactivates, 1 output, 2 input activates.
module gpio_line_message_irq_engine
  import gpio_msg_pkg::*;
(
  input  wire logic              I_CLOCK,
  input  wire logic              I_SRST,
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  input  wire logic [NGPIO-1:0]  I_GPIO_IN,
  output logic [NGPIO-1:0]       O_GPIO_OUT,
  output logic [NGPIO-1:0]       O_GPIO_OE
);

  // Bus state
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic              aw_full_q, aw_full_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              w_full_q, w_full_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;

  // Engine state
  cmd_state_t        state_q, state_d;
  cmd_req_t          req_q, req_d;
  cmd_resp_t         resp_q, resp_d;
  logic              irq_en_q, irq_en_d;
  line_state_t       lines_q [NGPIO], lines_d [NGPIO];
  logic              wr_fire, rd_fire, pop_hit;
  logic [IDX_W-1:0]  pop_idx;
  logic [31:0]       wmask, pop_word;
  logic [NGPIO-1:0]  pend_vec, oe_vec, lvl_vec;

  assign O_AWREADY = !aw_full_q && !bvalid_q;
  assign O_WREADY  = !w_full_q && !bvalid_q;
  assign O_ARREADY = !rvalid_q;
  assign O_BVALID  = bvalid_q;
  assign O_BRESP   = bresp_q;
  assign O_RVALID  = rvalid_q;
  assign O_RRESP   = rresp_q;
  assign O_RDATA   = rdata_q;
  assign wr_fire   = aw_full_q && w_full_q && !bvalid_q;
  assign rd_fire   = I_ARVALID && !rvalid_q;
  assign wmask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                      {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Per-line views and lowest pending returned pair
  always_comb begin
    pop_hit  = 1'b0;
    pop_idx  = '0;
    pend_vec = '0;
    oe_vec   = '0;
    lvl_vec  = '0;
    for (int i = NGPIO - 1; i >= 0; i--) begin
      pend_vec[i] = lines_q[i].ret_pend;
      oe_vec[i]   = (lines_q[i].dir == DIR_OUT);
      lvl_vec[i]  = lines_q[i].level;
      if (lines_q[i].ret_pend) begin
        pop_hit = 1'b1;
        pop_idx = IDX_W'(i);
      end
    end
    pop_word = ZERO32;
    if (pop_hit) begin
      pop_word[POP_VALID_BIT] = 1'b1;
      pop_word[POP_STAT_LSB +: 8] = lines_q[pop_idx].ret_stat;
      pop_word[15:0] = 16'(pop_idx);
    end
  end

  assign O_GPIO_OUT = lvl_vec & oe_vec;
  assign O_GPIO_OE  = oe_vec;

  // AXI4-Lite slave
  always_comb begin
    awaddr_d  = awaddr_q;
    aw_full_d = aw_full_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    w_full_d  = w_full_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (I_AWVALID && O_AWREADY) begin
      awaddr_d  = I_AWADDR;
      aw_full_d = 1'b1;
    end
    if (I_WVALID && O_WREADY) begin
      wdata_d  = I_WDATA;
      wstrb_d  = I_WSTRB;
      w_full_d = 1'b1;
    end
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = AXI_SLVERR;
      if (awaddr_q == ADDR_CMD_HEAD || awaddr_q == ADDR_CMD_VALUE ||
          awaddr_q == ADDR_CMD_GO || awaddr_q == ADDR_EVT_POST ||
          awaddr_q == ADDR_CTRL) begin
        bresp_d = AXI_OKAY;
      end
    end else if (bvalid_q && I_BREADY) begin
      bvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d  = AXI_OKAY;
      if (I_ARADDR == ADDR_CMD_HEAD) begin
        rdata_d = {req_q.line, req_q.msg_type};
      end else if (I_ARADDR == ADDR_CMD_VALUE) begin
        rdata_d = req_q.value;
      end else if (I_ARADDR == ADDR_CMD_RESP) begin
        rdata_d = ZERO32;
        rdata_d[RESP_DONE_BIT] = resp_q.done;
        rdata_d[7:0] = resp_q.status;
      end else if (I_ARADDR == ADDR_RESP_VALUE) begin
        rdata_d = resp_q.value;
      end else if (I_ARADDR == ADDR_EVT_POP) begin
        rdata_d = pop_word;
      end else if (I_ARADDR == ADDR_CONFIG) begin
        rdata_d = 32'(NGPIO);
      end else if (I_ARADDR == ADDR_NAMES_SIZE) begin
        rdata_d = NAMES_SIZE;
      end else if (I_ARADDR == ADDR_CTRL) begin
        rdata_d = 32'(irq_en_q);
      end else if (I_ARADDR == ADDR_LINE_STATE) begin
        rdata_d = {8'h00, oe_vec, pend_vec, I_GPIO_IN};
      end else begin
        rdata_d = ZERO32;
        rresp_d = AXI_SLVERR;
      end
    end else if (rvalid_q && I_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      awaddr_q  <= '0;
      aw_full_q <= 1'b0;
      wdata_q   <= ZERO32;
      wstrb_q   <= '0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= AXI_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= AXI_OKAY;
      rdata_q   <= ZERO32;
    end else begin
      awaddr_q  <= awaddr_d;
      aw_full_q <= aw_full_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      w_full_q  <= w_full_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // Command engine and line state
  always_comb begin
    logic [IDX_W-1:0] idx, pidx;
    logic             rise, fall, edge_hit, lvl_hit, line_ok;
    idx      = req_q.line[IDX_W-1:0];
    pidx     = wdata_q[IDX_W-1:0];
    rise     = 1'b0;
    fall     = 1'b0;
    edge_hit = 1'b0;
    lvl_hit  = 1'b0;
    line_ok  = (req_q.line < 16'(NGPIO));
    state_d  = state_q;
    req_d    = req_q;
    resp_d   = resp_q;
    irq_en_d = irq_en_q;
    lines_d  = lines_q;
    for (int i = 0; i < NGPIO; i++) begin
      rise = I_GPIO_IN[i] && !lines_q[i].prev;
      fall = !I_GPIO_IN[i] && lines_q[i].prev;
      edge_hit = (lines_q[i].trig[0] && rise) ||
                 (lines_q[i].trig[1] && fall);
      lvl_hit = (lines_q[i].trig == TRIG_LVL_HI && I_GPIO_IN[i]) ||
                (lines_q[i].trig == TRIG_LVL_LO && !I_GPIO_IN[i]);
      lines_d[i].prev = I_GPIO_IN[i];
      if (lines_q[i].unmasked &&
          (lines_q[i].latched || edge_hit || lvl_hit)) begin
        lines_d[i].unmasked = 1'b0;
        lines_d[i].latched  = 1'b0;
        lines_d[i].ret_pend = 1'b1;
        lines_d[i].ret_stat = IRQ_VALID;
      end else if (edge_hit) begin
        lines_d[i].latched = 1'b1;
      end
    end
    if (rd_fire && I_ARADDR == ADDR_EVT_POP && pop_hit &&
        lines_d[pop_idx].unmasked == lines_q[pop_idx].unmasked) begin
      lines_d[pop_idx].ret_pend = 1'b0;
    end
    if (wr_fire) begin
      if (awaddr_q == ADDR_CMD_HEAD) begin
        {req_d.line, req_d.msg_type} =
          ({req_q.line, req_q.msg_type} & ~wmask) | (wdata_q & wmask);
      end else if (awaddr_q == ADDR_CMD_VALUE) begin
        req_d.value = (req_q.value & ~wmask) | (wdata_q & wmask);
      end else if (awaddr_q == ADDR_CMD_GO && state_q == CMD_IDLE) begin
        state_d     = CMD_EXEC;
        resp_d.done = 1'b0;
      end else if (awaddr_q == ADDR_CTRL) begin
        irq_en_d = wdata_q[CTRL_IRQ_BIT];
      end else if (awaddr_q == ADDR_EVT_POST &&
                   wdata_q[15:0] < 16'(NGPIO)) begin
        if (lines_q[pidx].trig == TRIG_NONE) begin
          lines_d[pidx].ret_pend = 1'b1;
          lines_d[pidx].ret_stat = IRQ_INVALID;
        end else begin
          lines_d[pidx].unmasked = 1'b1;
        end
      end
    end
    case (state_q)
      CMD_IDLE: begin
        state_d = state_d;
      end
      CMD_EXEC: begin
        state_d       = CMD_IDLE;
        resp_d.done   = 1'b1;
        resp_d.status = STATUS_ERR;
        resp_d.value  = ZERO32;
        if (line_ok) begin
          if (req_q.msg_type == MSG_GET_DIR) begin
            resp_d.status = STATUS_OK;
            resp_d.value  = 32'(lines_q[idx].dir);
          end else if (req_q.msg_type == MSG_GET_LEVEL) begin
            resp_d.status = STATUS_OK;
            resp_d.value  = 32'(I_GPIO_IN[idx]);
          end else if (req_q.msg_type == SET_LEVEL_MESSAGE &&
                       req_q.value < 32'h0000_0002) begin
            resp_d.status       = STATUS_OK;
            lines_d[idx].level  = req_q.value[0];
          end else if (req_q.msg_type == MSG_SET_DIR &&
                       req_q.value <= 32'(DIR_IN)) begin
            resp_d.status     = STATUS_OK;
            lines_d[idx].dir  = req_q.value[1:0];
            if (req_q.value[1:0] == DIR_NONE) begin
              lines_d[idx].level   = 1'b0;
              lines_d[idx].trig    = TRIG_NONE;
              lines_d[idx].latched = 1'b0;
              if (lines_q[idx].unmasked) begin
                lines_d[idx].unmasked = 1'b0;
                lines_d[idx].ret_pend = 1'b1;
                lines_d[idx].ret_stat = IRQ_INVALID;
              end
            end
          end else if (req_q.msg_type == SET_TRIGGER_MESSAGE && irq_en_q &&
                       lines_q[idx].dir != DIR_OUT &&
                       (req_q.value <= 32'(TRIG_LVL_HI) ||
                        req_q.value == 32'(TRIG_LVL_LO))) begin
            resp_d.status        = STATUS_OK;
            lines_d[idx].trig    = req_q.value[7:0];
            lines_d[idx].latched = 1'b0;
            if (req_q.value[7:0] == TRIG_NONE && lines_q[idx].unmasked) begin
              lines_d[idx].unmasked = 1'b0;
              lines_d[idx].ret_pend = 1'b1;
              lines_d[idx].ret_stat = IRQ_INVALID;
            end
          end
        end
      end
      default: begin
        state_d = CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      state_q  <= CMD_IDLE;
      req_q    <= '0;
      resp_q   <= '0;
      irq_en_q <= 1'b0;
      lines_q  <= '{default: '0};
    end else begin
      state_q  <= state_d;
      req_q    <= req_d;
      resp_q   <= resp_d;
      irq_en_q <= irq_en_d;
      lines_q  <= lines_d;
    end
  end

endmodule // gpio_line_message_irq_engine

// [gpio_line_message_irq_engine_monitor.sv]
`timescale 1ns/10ps
module irq_engine_monitor
  import gpio_msg_pkg::*;
(
  input wire logic              I_CLOCK,
  input wire logic              I_SRST,
  input wire logic              I_AWVALID,
  input wire logic              O_AWREADY,
  input wire logic              I_WVALID,
  input wire logic              O_WREADY,
  input wire logic [1:0]        O_BRESP,
  input wire logic              O_BVALID,
  input wire logic              I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic              I_ARVALID,
  input wire logic              O_ARREADY,
  input wire logic [31:0]       O_RDATA,
  input wire logic [1:0]        O_RRESP,
  input wire logic              O_RVALID,
  input wire logic              I_RREADY,
  input wire logic [NGPIO-1:0]  O_GPIO_OUT,
  input wire logic [NGPIO-1:0]  O_GPIO_OE
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);

  a_b_hold: assert property (O_BVALID && !I_BREADY |=>
    O_BVALID && $stable(O_BRESP)) else $error("write answer dropped");
  a_r_hold: assert property (O_RVALID && !I_RREADY |=>
    O_RVALID && $stable(O_RDATA)) else $error("read answer dropped");
  a_r_turn: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  a_w_turn: assert property (I_AWVALID && O_AWREADY && I_WVALID
    && O_WREADY |-> ##[1:3] O_BVALID) else $error("write answer late");
  a_busy_refuse: assert property ((O_BVALID |-> !O_AWREADY &&
    !O_WREADY) and (O_RVALID |-> !O_ARREADY))
    else $error("request taken while busy");
  a_out_gated: assert property ((O_GPIO_OUT & ~O_GPIO_OE) == '0)
    else $error("level driven on non-output line");
  a_reset_idle: assert property ($past(I_SRST) |-> !O_BVALID &&
    !O_RVALID && O_GPIO_OE == '0) else $error("not idle after reset");
  a_names_zero: assert property (I_ARVALID && O_ARREADY &&
    I_ARADDR == ADDR_NAMES_SIZE |=> O_RDATA == NAMES_SIZE)
    else $error("names size not zero");
  a_line_count: assert property (I_ARVALID && O_ARREADY &&
    I_ARADDR == ADDR_CONFIG |=> O_RDATA == 32'(NGPIO))
    else $error("wrong line count");
  a_unmapped_err: assert property (I_ARVALID && O_ARREADY &&
    I_ARADDR > ADDR_LINE_STATE |=> O_RRESP == AXI_SLVERR &&
    O_RDATA == ZERO32) else $error("unmapped read accepted");
endmodule // irq_engine_monitor

bind gpio_line_message_irq_engine irq_engine_monitor irq_engine_monitor_inst (
  .I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
  .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
  .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_GPIO_OUT(O_GPIO_OUT), .O_GPIO_OE(O_GPIO_OE));

// [gpio_line_message_irq_engine_test.sv]
`timescale 1ns/10ps
module gpio_line_message_irq_engine_test
  import gpio_msg_pkg::*;
;
  logic             clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic             awready, wready, bvalid, arready, rvalid, a;
  logic [11:0]      awaddr, araddr;
  logic [31:0]      wdata, rdata, rd;
  logic [1:0]       bresp, rresp, rs;
  logic [NGPIO-1:0] gin, gout, goe, drive;
  logic [15:0]      ln;
  logic [7:0]       t;
  logic [7:0]       trigs [5];
  int               err_count, checked, i;

  gpio_line_message_irq_engine gpio_line_message_irq_engine_inst (
    .I_CLOCK(clk), .I_SRST(srst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_GPIO_IN(gin), .O_GPIO_OUT(gout), .O_GPIO_OE(goe));

  line_env line_env_inst (
    .i_out(gout), .i_oe(goe), .i_drive(drive), .o_line(gin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("Error bus wait expected answer seen none");
    end_sim();
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 64) hang();
    bready <= 1'b0;
    rs = bresp;
  endtask

  task automatic rdr(input logic [11:0] ad);
    int n;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 64) hang();
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask

  task automatic cmd(input logic [15:0] ty, input logic [15:0] l,
                     input logic [31:0] v, input logic [7:0] st);
    int n;
    wr(ADDR_CMD_HEAD, {l, ty});
    wr(ADDR_CMD_VALUE, v);
    wr(ADDR_CMD_GO, 32'h0000_0001);
    for (n = 0; n < 16; n++) begin
      rdr(ADDR_CMD_RESP);
      if (rd[RESP_DONE_BIT] === 1'b1) break;
    end
    if (n == 16) hang();
    chk("cmd status", 32'({rd[31], rd[7:0]}), 32'({1'b1, st}));
    if (st == STATUS_OK && ty != MSG_GET_DIR && ty != MSG_GET_LEVEL) begin
      rdr(ADDR_RESP_VALUE);
      chk("cmd value", rd, ZERO32);
    end
  endtask

  task automatic pop(input logic [31:0] exp);
    int n;
    for (n = 0; n < 8; n++) begin
      rdr(ADDR_EVT_POP);
      if (rd[POP_VALID_BIT] === 1'b1) break;
    end
    chk("event pop", rd, exp);
  endtask

  task automatic pulse(input logic [15:0] l, input logic lv);
    @(posedge clk);
    drive[l] <= lv;
    repeat (3) @(posedge clk);
    drive[l] <= !lv;
  endtask

  function automatic logic [31:0] evt(input logic [7:0] st,
                                      input logic [15:0] l);
    evt = {1'b1, 7'h00, st, l};
  endfunction

  function automatic logic act(input logic [7:0] tt);
    act = (tt == TRIG_RISE || tt == TRIG_BOTH || tt == TRIG_LVL_HI);
  endfunction

  initial begin
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    drive = '0;
    err_count = 0;
    checked = 0;
    trigs = '{TRIG_RISE, TRIG_FALL, TRIG_BOTH, TRIG_LVL_HI, TRIG_LVL_LO};
    void'($urandom(32'hFC98));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rdr(ADDR_CONFIG);
    chk("line count", rd, 32'(NGPIO));
    rdr(ADDR_NAMES_SIZE);
    chk("names size", rd, NAMES_SIZE);
    pop(ZERO32);
    wr(ADDR_EVT_POST, 32'(NGPIO));
    pop(ZERO32);
    rdr(12'h02C);
    chk("unmapped read", 32'(rs), 32'(AXI_SLVERR));
    wr(12'h030, 32'hFFFF_FFFF);
    chk("unmapped write", 32'(rs), 32'(AXI_SLVERR));
    $display("Test registers done");
    ln = 16'($urandom % NGPIO);
    cmd(SET_TRIGGER_MESSAGE, ln, 32'(TRIG_RISE), STATUS_ERR);
    wr(ADDR_CTRL, 32'h0000_0001);
    rdr(ADDR_CTRL);
    chk("ctrl", rd, 32'h0000_0001);
    cmd(SET_LEVEL_MESSAGE, ln, 32'h1, STATUS_OK);
    chk("out before dir", 32'(gout), ZERO32);
    cmd(MSG_SET_DIR, ln, 32'(DIR_OUT), STATUS_OK);
    chk("out level", 32'(gout), 32'h1 << ln);
    cmd(SET_TRIGGER_MESSAGE, ln, 32'(TRIG_RISE), STATUS_ERR);
    cmd(MSG_SET_DIR, ln, 32'(DIR_NONE), STATUS_OK);
    chk("oe after none", 32'(goe), ZERO32);
    cmd(MSG_SET_DIR, ln, 32'(DIR_OUT), STATUS_OK);
    chk("level discarded", 32'(gout), ZERO32);
    cmd(MSG_SET_DIR, ln, 32'(DIR_NONE), STATUS_OK);
    cmd(SET_LEVEL_MESSAGE, 16'(NGPIO), 32'h1, STATUS_ERR);
    cmd(16'h0007, ln, ZERO32, STATUS_ERR);
    cmd(SET_LEVEL_MESSAGE, ln, 32'h2, STATUS_ERR);
    cmd(MSG_SET_DIR, ln, 32'h3, STATUS_ERR);
    chk("oe unchanged", 32'(goe), ZERO32);
    $display("Test output level done");
    for (i = 0; i < 5; i++) begin
      t = trigs[i];
      a = act(t);
      ln = 16'($urandom % NGPIO);
      @(posedge clk);
      drive[ln] <= !a;
      cmd(MSG_SET_DIR, ln, 32'(DIR_IN), STATUS_OK);
      cmd(MSG_GET_DIR, ln, ZERO32, STATUS_OK);
      rdr(ADDR_RESP_VALUE);
      chk("direction", rd, 32'(DIR_IN));
      cmd(MSG_GET_LEVEL, ln, ZERO32, STATUS_OK);
      rdr(ADDR_RESP_VALUE);
      chk("line level", rd, 32'(!a));
      cmd(SET_TRIGGER_MESSAGE, ln, 32'(t), STATUS_OK);
      pulse(ln, a);
      wr(ADDR_EVT_POST, 32'(ln));
      if (i >= 3) begin
        pop(ZERO32);
        @(posedge clk);
        drive[ln] <= a;
        pop(evt(IRQ_VALID, ln));
        pop(ZERO32);
        @(posedge clk);
        drive[ln] <= !a;
      end else begin
        pop(evt(IRQ_VALID, ln));
      end
      pulse(ln, a);
      cmd(SET_TRIGGER_MESSAGE, ln, 32'(TRIG_NONE), STATUS_OK);
      cmd(SET_TRIGGER_MESSAGE, ln, 32'(t), STATUS_OK);
      wr(ADDR_EVT_POST, 32'(ln));
      pop(ZERO32);
      cmd(SET_TRIGGER_MESSAGE, ln, 32'(TRIG_NONE), STATUS_OK);
      pop(evt(IRQ_INVALID, ln));
      cmd(MSG_SET_DIR, ln, 32'(DIR_NONE), STATUS_OK);
      wr(ADDR_EVT_POST, 32'(ln));
      pop(evt(IRQ_INVALID, ln));
      rdr(ADDR_LINE_STATE);
      chk("line state", rd, 32'(drive));
      $display("Test trigger %h done", t);
    end
    end_sim();
  end
endmodule // gpio_line_message_irq_engine_test

// [gpio_line_message_irq_engine_unused.sv]
`timescale 1ns/10ps

// [gpio_msg_pkg.sv]
package gpio_msg_pkg;

  localparam int unsigned NGPIO = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned ADDR_W = 12;

  // Register byte offsets
  localparam logic [11:0] ADDR_CMD_HEAD   = 12'h000;
  localparam logic [11:0] ADDR_CMD_VALUE  = 12'h004;
  localparam logic [11:0] ADDR_CMD_GO     = 12'h008;
  localparam logic [11:0] ADDR_CMD_RESP   = 12'h00C;
  localparam logic [11:0] ADDR_RESP_VALUE = 12'h010;
  localparam logic [11:0] ADDR_EVT_POST   = 12'h014;
  localparam logic [11:0] ADDR_EVT_POP    = 12'h018;
  localparam logic [11:0] ADDR_CONFIG     = 12'h01C;
  localparam logic [11:0] ADDR_NAMES_SIZE = 12'h020;
  localparam logic [11:0] ADDR_CTRL       = 12'h024;
  localparam logic [11:0] ADDR_LINE_STATE = 12'h028;

  // Field positions
  localparam int unsigned RESP_DONE_BIT = 31;
  localparam int unsigned POP_VALID_BIT = 31;
  localparam int unsigned POP_STAT_LSB  = 16;
  localparam int unsigned CTRL_IRQ_BIT  = 0;

  // Message types
  localparam logic [15:0] MSG_GET_NAMES       = 16'h0001;
  localparam logic [15:0] MSG_GET_DIR         = 16'h0002;
  localparam logic [15:0] MSG_SET_DIR         = 16'h0003;
  localparam logic [15:0] MSG_GET_LEVEL       = 16'h0004;
  localparam logic [15:0] SET_LEVEL_MESSAGE   = 16'h0005;
  localparam logic [15:0] SET_TRIGGER_MESSAGE = 16'h0006;

  // Direction codes
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_OUT  = 2'h1;
  localparam logic [1:0] DIR_IN   = 2'h2;

  // Trigger codes
  localparam logic [7:0] TRIG_NONE    = 8'h00;
  localparam logic [7:0] TRIG_RISE    = 8'h01;
  localparam logic [7:0] TRIG_FALL    = 8'h02;
  localparam logic [7:0] TRIG_BOTH    = 8'h03;
  localparam logic [7:0] TRIG_LVL_HI  = 8'h04;
  localparam logic [7:0] TRIG_LVL_LO  = 8'h08;

  // Status codes
  localparam logic [7:0] STATUS_OK   = 8'h00;
  localparam logic [7:0] STATUS_ERR  = 8'h01;
  localparam logic [7:0] IRQ_INVALID = 8'h00;
  localparam logic [7:0] IRQ_VALID   = 8'h01;

  // Bus answers and reset values
  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;
  localparam logic [31:0] NAMES_SIZE = 32'h0000_0000;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;

  typedef struct packed {
    logic [15:0] line;
    logic [15:0] msg_type;
    logic [31:0] value;
  } cmd_req_t;

  typedef struct packed {
    logic        done;
    logic [7:0]  status;
    logic [31:0] value;
  } cmd_resp_t;

  typedef struct packed {
    logic [1:0] dir;
    logic       level;
    logic [7:0] trig;
    logic       prev;
    logic       latched;
    logic       unmasked;
    logic       ret_pend;
    logic [7:0] ret_stat;
  } line_state_t;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b01,
    CMD_EXEC = 2'b10
  } cmd_state_t;

endpackage

// [line_env.sv]
`timescale 1ns/10ps
module line_env
  import gpio_msg_pkg::*;
(
  input  wire logic [NGPIO-1:0] i_out,
  input  wire logic [NGPIO-1:0] i_oe,
  input  wire logic [NGPIO-1:0] i_drive,
  output logic      [NGPIO-1:0] o_line
);
  // Output lines read back, others follow the far-side source
  assign o_line = (i_out & i_oe) | (i_drive & ~i_oe);
endmodule // line_env
